// file: lane_conditioning_config_regs.sv
`timescale 1ns/1ps
module lane_conditioning_config_regs
  import lane_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = SMB_DEV_ADDR_DEF,  // arbitrary value
  parameter int PERIOD_CYC = DETECT_PERIOD_CYC,
  parameter int MAX_TRIES = DETECT_MAX_TRIES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // management bus pins
  input wire logic smb_scl_i,
  input wire logic smb_sda_i,
  output logic smb_sda_o,
  output logic smb_sda_oe_o,
  // global override, same clock
  input wire logic detect_override_en_i,
  input wire logic [1:0] a1_strap_mode_i,
  input wire logic [1:0] b1_strap_mode_i,
  // analog observations, asynchronous
  input wire logic out0_rx_seen_i,
  input wire logic [1:0] out0_mode_i,
  input wire logic a1_rx_present_i,
  input wire logic b1_rx_present_i,
  // analog controls
  output logic [2:0] deemph_level_o,
  output logic [7:0] a1_boost_o,
  output logic [7:0] b1_boost_o,
  output logic a1_term_50_o,
  output logic b1_term_50_o,
  output logic a1_probe_o,
  output logic b1_probe_o
);

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int SYNC_W = 7;
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync1_q;  // first stage, read only by sync2_q
  logic [SYNC_W-1:0] sync2_q;  // safe copies
  logic scl_prev_q;
  logic sda_prev_q;

  assign async_in = {smb_scl_i, smb_sda_i, out0_rx_seen_i, out0_mode_i,
    a1_rx_present_i, b1_rx_present_i};

  // two flops on every pin; bus idles high
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= 7'h60;
      sync2_q <= 7'h60;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      scl_prev_q <= sync2_q[6];
      sda_prev_q <= sync2_q[5];
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl = sync2_q[6];
  assign sda = sync2_q[5];
  assign scl_rise = scl && !scl_prev_q;
  assign scl_fall = !scl && scl_prev_q;
  // sda moving while scl is high frames a transfer
  assign bus_start = scl && scl_prev_q && sda_prev_q && !sda;
  assign bus_stop = scl && scl_prev_q && !sda_prev_q && sda;

  // ****************************************
  // registers
  // ****************************************
  logic [4:0] out0_ctl_q;  // reserved 4:3 and de-emphasis 2:0
  logic [7:0] rsvd19_q;
  logic [7:0] a1_det_q;
  logic [7:0] a1_boost_q;
  logic [7:0] rsvd1e_q;
  logic [7:0] rsvd1f_q;
  logic [7:0] rsvd20_q;
  logic [7:0] b1_det_q;
  logic [7:0] b1_boost_q;
  logic wr_en;  // byte write strobe from the bus engine
  logic [7:0] ptr_q;  // register pointer
  logic [7:0] shift_q;  // received byte

  // read mux; unmapped offsets read zero
  function automatic logic [7:0] reg_read(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (addr == OFS_OUT0_DEEMPH) begin
      v = {sync2_q[4], sync2_q[3:2], out0_ctl_q};
    end else if (addr == OFS_RSVD_19) begin
      v = rsvd19_q;
    end else if (addr == OFS_A1_DETECT) begin
      v = a1_det_q;
    end else if (addr == OFS_A1_BOOST) begin
      v = a1_boost_q;
    end else if (addr == OFS_RSVD_1E) begin
      v = rsvd1e_q;
    end else if (addr == OFS_RSVD_1F) begin
      v = rsvd1f_q;
    end else if (addr == OFS_RSVD_20) begin
      v = rsvd20_q;
    end else if (addr == OFS_B1_DETECT) begin
      v = b1_det_q;
    end else if (addr == OFS_B1_BOOST) begin
      v = b1_boost_q;
    end
    return v;
  endfunction

  // register writes; reserved bits are stored as written
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out0_ctl_q <= RST_OUT0_DEEMPH[4:0];
      rsvd19_q <= RST_RSVD_19;
      a1_det_q <= RST_DETECT;
      a1_boost_q <= RST_BOOST;
      rsvd1e_q <= RST_RSVD_1E;
      rsvd1f_q <= RST_RSVD_1F;
      rsvd20_q <= RST_RSVD_20;
      b1_det_q <= RST_DETECT;
      b1_boost_q <= RST_BOOST;
    end else if (wr_en) begin
      if (ptr_q == OFS_OUT0_DEEMPH) begin
        out0_ctl_q <= shift_q[4:0];  // status bits 7:5 dropped
      end else if (ptr_q == OFS_RSVD_19) begin
        rsvd19_q <= shift_q;
      end else if (ptr_q == OFS_A1_DETECT) begin
        a1_det_q <= shift_q;
      end else if (ptr_q == OFS_A1_BOOST) begin
        a1_boost_q <= shift_q;
      end else if (ptr_q == OFS_RSVD_1E) begin
        rsvd1e_q <= shift_q;
      end else if (ptr_q == OFS_RSVD_1F) begin
        rsvd1f_q <= shift_q;
      end else if (ptr_q == OFS_RSVD_20) begin
        rsvd20_q <= shift_q;
      end else if (ptr_q == OFS_B1_DETECT) begin
        b1_det_q <= shift_q;
      end else if (ptr_q == OFS_B1_BOOST) begin
        b1_boost_q <= shift_q;
      end
    end
  end

  assign deemph_level_o = out0_ctl_q[DEEMPH_HI:0];
  assign a1_boost_o = a1_boost_q;
  assign b1_boost_o = b1_boost_q;

  // ****************************************
  // bus engine
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } smb_state_t;

  smb_state_t state_q;
  logic [3:0] bits_q;  // bits moved in the current byte
  logic read_q;  // direction bit of the address byte
  logic [7:0] tx_q;  // byte being sent, msb on the wire
  logic host_ack_q;  // host acked the last read byte
  logic byte_in;  // eighth bit received, at scl fall

  assign byte_in = scl_fall && (bits_q == SMB_BYTE_BITS);
  assign wr_en = byte_in && (state_q == ST_WR);
  // open drain: only ever pull low
  assign smb_sda_o = 1'b0;
  assign smb_sda_oe_o = (state_q == ST_ADDR_ACK) || (state_q == ST_PTR_ACK) ||
    (state_q == ST_WR_ACK) || (state_q == ST_RD && !tx_q[7]);

  // byte framing and acknowledge slots; bits and the host ack are taken on scl rise, state changes land on scl fall
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      bits_q <= 4'h0;
      shift_q <= 8'h00;
      read_q <= 1'b0;
      tx_q <= 8'hff;
      host_ack_q <= 1'b0;
      ptr_q <= 8'h00;
    end else if (bus_stop) begin
      state_q <= ST_IDLE;
    end else if (bus_start) begin
      // repeated start keeps the pointer for a following read
      state_q <= ST_ADDR;
      bits_q <= 4'h0;
    end else begin
      case (state_q)
        ST_ADDR, ST_PTR, ST_WR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda};
            bits_q <= bits_q + 4'h1;
          end else if (byte_in) begin
            bits_q <= 4'h0;
            if (state_q == ST_ADDR) begin
              // foreign addresses are left alone until the next start
              state_q <= (shift_q[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
              read_q <= shift_q[0];
            end else if (state_q == ST_PTR) begin
              ptr_q <= shift_q;
              state_q <= ST_PTR_ACK;
            end else begin
              ptr_q <= ptr_q + 8'h1;  // burst writes walk upward
              state_q <= ST_WR_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            if (state_q == ST_ADDR_ACK && read_q) begin
              tx_q <= reg_read(ptr_q);
              ptr_q <= ptr_q + 8'h1;
              bits_q <= 4'h1;
              state_q <= ST_RD;
            end else begin
              state_q <= (state_q == ST_ADDR_ACK) ? ST_PTR : ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bits_q == SMB_BYTE_BITS) begin
              tx_q <= 8'hff;
              state_q <= ST_RD_ACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b1};
              bits_q <= bits_q + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            host_ack_q <= !sda;
          end else if (scl_fall) begin
            if (host_ack_q) begin
              tx_q <= reg_read(ptr_q);
              ptr_q <= ptr_q + 8'h1;
              bits_q <= 4'h1;
              state_q <= ST_RD;
            end else begin
              state_q <= ST_IDLE;  // host nack ends the read
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // detection lanes
  // ****************************************
  logic [1:0] lane_mode [2];
  logic [1:0] lane_cfg [2];
  logic [1:0] lane_strap [2];
  logic [1:0] lane_present;
  logic [1:0] lane_probe;
  logic [1:0] lane_term;

  assign lane_cfg[0] = a1_det_q[DETECT_HI:DETECT_LO];
  assign lane_cfg[1] = b1_det_q[DETECT_HI:DETECT_LO];
  assign lane_strap[0] = a1_strap_mode_i;
  assign lane_strap[1] = b1_strap_mode_i;
  assign lane_present = sync2_q[1:0] ^ 2'h0;
  assign a1_probe_o = lane_probe[1];
  assign b1_probe_o = lane_probe[0];
  assign a1_term_50_o = lane_term[1];
  assign b1_term_50_o = lane_term[0];

  for (genvar i = 0; i < 2; i++) begin : g_lane
    // register field applies only under the global override
    assign lane_mode[i] = detect_override_en_i ? lane_cfg[i] : lane_strap[i];
    rx_detect_seq #(
      .PERIOD_CYC(PERIOD_CYC),
      .MAX_TRIES(MAX_TRIES)
    ) u_seq (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .mode_i(lane_mode[i]),
      .rx_present_i(lane_present[1-i]),
      .probe_o(lane_probe[1-i]),
      .term_50_o(lane_term[1-i]),
      .seen_o()
    );
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  logic [7:0] view18;
  // always_comb wakes on what the function reads; a plain assign would go stale
  always_comb view18 = reg_read(OFS_OUT0_DEEMPH);

  // status bits are held against the pins two clocks back, the synchroniser depth
  a_seen_status: assert property (view18[SEEN_BIT] == $past(out0_rx_seen_i, 2))
    else $error("seen bit not tracking the lane");
  a_mode_readonly: assert property (wr_en && ptr_q == OFS_OUT0_DEEMPH
    |=> view18[MODE_HI:MODE_LO] == $past(out0_mode_i, 2))
    else $error("mode status took a written value");
  a_deemph_write: assert property (wr_en && ptr_q == OFS_OUT0_DEEMPH
    |=> deemph_level_o == $past(shift_q[2:0]))
    else $error("de-emphasis write lost");
  // without the override the strap alone decides the termination
  a_override_gate: assert property (!$past(detect_override_en_i)
    && $past(a1_strap_mode_i) inside {DET_HIGHZ, DET_FORCED}
    |-> a1_term_50_o == ($past(a1_strap_mode_i) == DET_FORCED))
    else $error("lane field used without override");
  a_boost_write: assert property (wr_en && ptr_q == OFS_B1_BOOST
    |=> b1_boost_o == $past(shift_q) ##1 b1_boost_o == $past(b1_boost_o))
    else $error("boost write lost");
  c_reg_write: cover property (wr_en && ptr_q == OFS_A1_BOOST);
  c_reg_read: cover property (state_q == ST_RD_ACK && scl_fall && host_ack_q);

endmodule

// file: lane_cfg_pkg.sv
// Notes on behaviour
// - status bit 7 shows far receiver detected
// - mode status bits 6:5 read-only, writes ignored
// - de-emphasis select bits 2:0, resets to 010
// - detect field 00: high-z, no detection
// - field 01: probe every 12 ms, 50 tries
// - field 10: probe every 12 ms until found
// - field 11: 50 ohm always, no detection
// - lane field used only under global override
// - boost register 8-bit read/write, resets 0x2f
package lane_cfg_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_OUT0_DEEMPH = 8'h18;
  localparam logic [7:0] OFS_RSVD_19 = 8'h19;
  localparam logic [7:0] OFS_A1_DETECT = 8'h1c;
  localparam logic [7:0] OFS_A1_BOOST = 8'h1d;
  localparam logic [7:0] OFS_RSVD_1E = 8'h1e;
  localparam logic [7:0] OFS_RSVD_1F = 8'h1f;
  localparam logic [7:0] OFS_RSVD_20 = 8'h20;
  localparam logic [7:0] OFS_B1_DETECT = 8'h23;
  localparam logic [7:0] OFS_B1_BOOST = 8'h24;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [7:0] RST_OUT0_DEEMPH = 8'h02;
  localparam logic [7:0] RST_RSVD_19 = 8'h00;
  localparam logic [7:0] RST_DETECT = 8'h00;
  localparam logic [7:0] RST_BOOST = 8'h2f;
  localparam logic [7:0] RST_RSVD_1E = 8'had;
  localparam logic [7:0] RST_RSVD_1F = 8'h02;
  localparam logic [7:0] RST_RSVD_20 = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SEEN_BIT = 7;
  localparam int MODE_HI = 6;
  localparam int MODE_LO = 5;
  localparam int DEEMPH_HI = 2;
  localparam int DETECT_HI = 3;
  localparam int DETECT_LO = 2;

  // detect field encodings
  typedef enum logic [1:0] {
    DET_HIGHZ = 2'h0,
    DET_LIMITED = 2'h1,
    DET_ENDLESS = 2'h2,
    DET_FORCED = 2'h3
  } detect_mode_t;

  // de-emphasis encodings, 0 dB down to -12 dB
  typedef enum logic [2:0] {
    DEEMPH_0DB = 3'h0, DEEMPH_M1P5DB = 3'h1, DEEMPH_M3P5DB = 3'h2, DEEMPH_M5DB = 3'h3,
    DEEMPH_M6DB = 3'h4, DEEMPH_M8DB = 3'h5, DEEMPH_M9DB = 3'h6, DEEMPH_M12DB = 3'h7
  } deemph_level_t;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int DETECT_PERIOD_MS = 12;
  localparam int DETECT_PERIOD_CYC = DETECT_PERIOD_MS * CLK_FREQ_KHZ;
  localparam int DETECT_MAX_TRIES = 50;
  localparam int DETECT_TIMER_W = 21;

  // serial management bus
  localparam logic [6:0] SMB_DEV_ADDR_DEF = 7'h2a;  // arbitrary value
  localparam logic [3:0] SMB_BYTE_BITS = 4'h8;

endpackage

// file: rx_detect_seq.sv
`timescale 1ns/1ps
module rx_detect_seq
  import lane_cfg_pkg::*;
#(
  parameter int PERIOD_CYC = DETECT_PERIOD_CYC,
  parameter int MAX_TRIES = DETECT_MAX_TRIES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // effective mode and probe result (already synchronised)
  input wire logic [1:0] mode_i,
  input wire logic rx_present_i,
  // termination and probe control
  output logic probe_o,
  output logic term_50_o,
  output logic seen_o
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (PERIOD_CYC < 1 || PERIOD_CYC >= (1 << DETECT_TIMER_W)) begin : g_bad_period
    $error("period count out of range");
  end
  if (MAX_TRIES < 1 || MAX_TRIES > 255) begin : g_bad_tries
    $error("try count out of range");
  end

  localparam logic [DETECT_TIMER_W-1:0] RELOAD = DETECT_TIMER_W'(PERIOD_CYC - 1);
  localparam logic [7:0] TRY_LIMIT = 8'(MAX_TRIES);

  detect_mode_t mode;
  detect_mode_t mode_prev_q;  // restarts the sequence on change
  logic [DETECT_TIMER_W-1:0] timer_q;  // cycles to the next probe
  logic [7:0] tries_q;  // probes spent since the last mode change, in either auto mode
  logic seen_q;  // receiver found
  logic probing;  // a probe fires this cycle
  logic done;  // limited mode ran out of tries

  assign mode = detect_mode_t'(mode_i);
  assign done = (mode == DET_LIMITED) && (tries_q == TRY_LIMIT);
  // probe only in the auto modes, before a find, at timer expiry
  assign probing = (mode == DET_LIMITED || mode == DET_ENDLESS) && (mode_prev_q == mode)
    && !seen_q && !done && (timer_q == '0);
  assign probe_o = probing;
  assign seen_o = seen_q;

  // ****************************************
  // sequencer
  // ****************************************
  // the result is taken in the probe cycle; the analog side holds it as a level
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_prev_q <= DET_HIGHZ;
      timer_q <= '0;
      tries_q <= '0;
      seen_q <= 1'b0;
    end else begin
      mode_prev_q <= mode;
      if (mode_prev_q != mode) begin
        // new mode: start again with an immediate probe
        timer_q <= '0;
        tries_q <= '0;
        seen_q <= 1'b0;
      end else if (probing) begin
        timer_q <= RELOAD;
        tries_q <= tries_q + 8'h1;
        seen_q <= rx_present_i;
      end else if (timer_q != '0) begin
        timer_q <= timer_q - 1'b1;
      end
    end
  end

  // termination: forced, or after a find in the auto modes
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      term_50_o <= 1'b0;
    end else begin
      term_50_o <= (mode == DET_FORCED) ||
        ((mode == DET_LIMITED || mode == DET_ENDLESS) && seen_q);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_highz_quiet: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    mode == DET_HIGHZ && $past(mode) == DET_HIGHZ |-> !probe_o && !term_50_o)
    else $error("high-z mode probed or terminated");
  a_tries_bounded: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    probe_o && mode == DET_LIMITED |-> tries_q < TRY_LIMIT)
    else $error("limited mode exceeded its tries");
  a_probe_spacing: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    probe_o ##1 (mode == $past(mode)) |-> timer_q == RELOAD)
    else $error("probe period not reloaded");
  a_forced_term: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    mode == DET_FORCED |=> !probe_o && (term_50_o || $past(mode) != DET_FORCED))
    else $error("forced mode not terminated");
  c_found: cover property (@(posedge mclk_i) disable iff (!resetn_i) $rose(seen_q));
  c_gave_up: cover property (@(posedge mclk_i) disable iff (!resetn_i) $rose(done));

endmodule

// file: smb_host_model.sv
`timescale 1ns/1ps
// management bus host: drives the bus clock, pulls data low only (open drain)
module smb_host_model (
  // clock
  input wire logic mclk_i,
  // bus wires
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // scl half period in mclk cycles, twice the 4-cycle minimum
  localparam int HALF_CYC = 8;

  // bus idles released, clock high
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // ****************************************
  // bit level
  // ****************************************
  task automatic half();
    repeat (HALF_CYC) @(negedge mclk_i);
  endtask

  // data changes only while scl is low; sampled just before scl falls
  task automatic bit_xfer(input logic b, output logic got);
    sda_oe_o = ~b;
    half();
    scl_o = 1'b1;
    half();
    got = sda_i;
    scl_o = 1'b0;
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_oe_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_oe_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask

  // stop: sda rises while scl is high
  task automatic stop();
    sda_oe_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_oe_o = 1'b0;
    half();
  endtask

  // ****************************************
  // byte level and register cycles
  // ****************************************
  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], g);
    bit_xfer(1'b1, g);
    ack = ~g;
  endtask

  // last high answers nack, ending the read
  task automatic byte_in(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, g);
      d[i] = g;
    end
    bit_xfer(last, g);
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    start();
    byte_out({dev, 1'b0}, a0);
    byte_out(ofs, a1);
    byte_out(d, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                          output logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    start();
    byte_out({dev, 1'b0}, a0);
    byte_out(ofs, a1);
    start();
    byte_out({dev, 1'b1}, a2);
    byte_in(1'b1, d);
    stop();
    ack = a0 & a1 & a2;
  endtask
endmodule

// file: lane_conditioning_config_regs_bench.sv
`timescale 1ns/1ps
module lane_conditioning_config_regs_bench;
  import lane_cfg_pkg::*;
  // short detect timing keeps the run small
  localparam int PER = 20;
  localparam int TRIES = 3;
  localparam int CEILING = 80000;
  logic mclk, resetn, scl_w, host_oe, dut_oe, dut_sda_o, sda_w, override_en;
  logic out0_seen;
  logic [1:0] out0_mode;
  logic [1:0] strap [2];
  logic [1:0] rx_present;
  logic [1:0] term, probe;
  logic [2:0] deemph;
  logic [7:0] boost [2];
  int n_probe [2];
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] det_ofs [2] = '{OFS_A1_DETECT, OFS_B1_DETECT};
  logic [7:0] bst_ofs [2] = '{OFS_A1_BOOST, OFS_B1_BOOST};

  // wire level: pulled up, low when either party pulls
  assign sda_w = (dut_oe ? dut_sda_o : 1'b1) & ~host_oe;

  lane_conditioning_config_regs #(.PERIOD_CYC(PER), .MAX_TRIES(TRIES)) dut_u (
    .mclk_i(mclk), .resetn_i(resetn), .smb_scl_i(scl_w), .smb_sda_i(sda_w),
    .smb_sda_o(dut_sda_o), .smb_sda_oe_o(dut_oe), .detect_override_en_i(override_en),
    .a1_strap_mode_i(strap[0]), .b1_strap_mode_i(strap[1]), .out0_rx_seen_i(out0_seen),
    .out0_mode_i(out0_mode), .a1_rx_present_i(rx_present[0]),
    .b1_rx_present_i(rx_present[1]), .deemph_level_o(deemph), .a1_boost_o(boost[0]),
    .b1_boost_o(boost[1]), .a1_term_50_o(term[0]), .b1_term_50_o(term[1]),
    .a1_probe_o(probe[0]), .b1_probe_o(probe[1])
  );

  smb_host_model host_u (.mclk_i(mclk), .sda_i(sda_w), .scl_o(scl_w), .sda_oe_o(host_oe));

  // ****************************************
  // clock, probe counting, hang guard
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // probe is a one-cycle pulse, so every cycle is looked at
  always @(posedge mclk) begin
    for (int l = 0; l < 2; l++) if (probe[l] === 1'b1) n_probe[l]++;
    cycles++;
    if (cycles == CEILING) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic a;
    host_u.write_reg(SMB_DEV_ADDR_DEF, ofs, d, a);
    check({7'h0, a}, 8'h01, "write ack");
  endtask

  task automatic rd_check(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    logic a;
    host_u.read_reg(SMB_DEV_ADDR_DEF, ofs, d, a);
    check({7'h0, a}, 8'h01, "read ack");
    check(d, exp, "read data");
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // every register after reset, plus an unmapped offset that reads zero
  task automatic t_reset();
    logic [7:0] ofs [10] = '{8'h18, 8'h19, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h23,
                             8'h24, 8'h1a};
    logic [7:0] val [10] = '{8'h02, 8'h00, 8'h00, 8'h2f, 8'had, 8'h02, 8'h00, 8'h00,
                             8'h2f, 8'h00};
    check({5'h0, deemph}, 8'h02, "deemph out");
    check(boost[0], 8'h2f, "a1 boost out");
    check(boost[1], 8'h2f, "b1 boost out");
    for (int i = 0; i < 10; i++) rd_check(ofs[i], val[i]);
  endtask

  // status bits follow the pins, writes to them are dropped
  task automatic t_status();
    out0_seen = 1'b0;
    out0_mode = 2'b01;
    wr(OFS_OUT0_DEEMPH, 8'he5);
    rd_check(OFS_OUT0_DEEMPH, 8'h25);
    out0_seen = 1'b1;
    out0_mode = 2'b10;
    cyc(5);
    rd_check(OFS_OUT0_DEEMPH, 8'hc5);
  endtask

  // every de-emphasis code reaches the output and reads back
  task automatic t_deemph();
    for (int c = 0; c < 8; c++) begin
      wr(OFS_OUT0_DEEMPH, 8'(c));
      check({5'h0, deemph}, 8'(c), "deemph out");
      rd_check(OFS_OUT0_DEEMPH, 8'hc0 | 8'(c));
    end
  endtask

  // full 8-bit range on both lanes; a foreign device address is ignored
  task automatic t_boost();
    logic [7:0] v [3] = '{8'hff, 8'h00, 8'h5a};
    logic a;
    for (int i = 0; i < 3; i++) begin
      wr(OFS_A1_BOOST, v[i]);
      wr(OFS_B1_BOOST, ~v[i]);
      check(boost[0], v[i], "a1 boost out");
      check(boost[1], ~v[i], "b1 boost out");
      rd_check(OFS_A1_BOOST, v[i]);
      rd_check(OFS_B1_BOOST, ~v[i]);
    end
    host_u.write_reg(SMB_DEV_ADDR_DEF ^ 7'h01, OFS_A1_BOOST, 8'h11, a);
    check({7'h0, a}, 8'h00, "foreign address ack");
    rd_check(OFS_A1_BOOST, v[2]);
  endtask

  // reserved bits stay zero in the detect field writes
  task automatic set_mode(input int l, input logic [1:0] m);
    n_probe[l] = 0;
    wr(det_ofs[l], {4'h0, m, 2'h0});
  endtask

  // all four detect modes, then the override gate
  task automatic t_detect(input int l);
    override_en = 1'b1;
    rx_present[l] = 1'b0;
    set_mode(l, DET_HIGHZ);
    cyc(100);
    check(8'(n_probe[l]), 8'h00, "high-z probes");
    check({7'h0, term[l]}, 8'h00, "high-z term");
    set_mode(l, DET_FORCED);
    check({7'h0, term[l]}, 8'h01, "forced term");
    cyc(100);
    check(8'(n_probe[l]), 8'h00, "forced probes");
    set_mode(l, DET_LIMITED);
    cyc(TRIES * PER + 60);
    check(8'(n_probe[l]), 8'(TRIES), "limited probes");
    rx_present[l] = 1'b1;
    cyc(3 * PER);
    check({7'h0, term[l]}, 8'h00, "limited term after stop");
    rx_present[l] = 1'b0;
    set_mode(l, DET_ENDLESS);
    cyc(TRIES * PER + 60);
    check({7'h0, n_probe[l] > TRIES}, 8'h01, "endless probes go on");
    check({7'h0, term[l]}, 8'h00, "endless term before");
    rx_present[l] = 1'b1;
    cyc(PER + 10);
    check({7'h0, term[l]}, 8'h01, "endless term after");
    n_probe[l] = 0;
    cyc(3 * PER);
    check(8'(n_probe[l]), 8'h00, "endless stops when found");
    set_mode(l, DET_LIMITED);
    cyc(10);
    check({7'h0, term[l]}, 8'h01, "limited term found");
    // override low: the strap rules, the register field is ignored
    override_en = 1'b0;
    strap[l] = DET_HIGHZ;
    cyc(10);
    n_probe[l] = 0;
    cyc(3 * PER);
    check({7'h0, term[l]}, 8'h00, "strap high-z term");
    check(8'(n_probe[l]), 8'h00, "strap high-z probes");
    strap[l] = DET_FORCED;
    cyc(5);
    check({7'h0, term[l]}, 8'h01, "strap forced term");
    strap[l] = DET_HIGHZ;
    override_en = 1'b1;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    override_en = 1'b0;
    strap = '{DET_HIGHZ, DET_HIGHZ};
    out0_seen = 1'b0;
    out0_mode = 2'b00;
    rx_present = 2'b00;
    n_probe = '{0, 0};
    cyc(4);
    resetn = 1'b1;
    cyc(5);
    t_reset();
    t_status();
    t_deemph();
    t_boost();
    t_detect(0);
    t_detect(1);
    finish_test();
  end
endmodule
